//--- pkg/mcc_pkg.sv
// Constants and types shared by the monitor configuration register group.
`default_nettype none

package mcc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] MCC_OFS_PARITY_TEST = 8'h6F;
  localparam logic [7:0] MCC_OFS_REMOTE_ONE_OFFSET = 8'h70;
  localparam logic [7:0] MCC_OFS_LOCAL_OFFSET = 8'h71;
  localparam logic [7:0] MCC_OFS_REMOTE_TWO_OFFSET = 8'h72;
  localparam logic [7:0] MCC_OFS_MEAS_CONFIG_TWO = 8'h73;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] MCC_RST_PARITY_TEST = 8'h00;
  localparam logic [7:0] MCC_RST_OFFSET = 8'h00;
  localparam logic [7:0] MCC_RST_MEAS_CONFIG_TWO = 8'h00;
  localparam logic [7:0] MCC_READ_IDLE = 8'h00;
  localparam logic [7:0] MCC_DUTY_IDLE = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MCC_BIT_PARITY_TEST_ON = 0;
  localparam int MCC_BIT_TWO_WIRE_LO = 0;
  localparam int MCC_BIT_TWO_WIRE_HI = 3;
  localparam int MCC_BIT_AVERAGING_DISABLE = 4;
  localparam int MCC_BIT_ATTENUATOR_BYPASS = 5;
  localparam int MCC_BIT_SINGLE_CHANNEL = 6;
  localparam int MCC_BIT_SHUTDOWN_SELECT = 7;
  localparam int MCC_BIT_EXT_START_ENABLE = 2;

  // ----------------------------------------------------------------
  // Widths and ranges
  // ----------------------------------------------------------------
  localparam int MCC_TEMP_W = 10;
  localparam int MCC_SUM_W = 11;
  localparam int MCC_FANS = 4;
  localparam int MCC_PWMS = 3;
  localparam logic signed [MCC_SUM_W-1:0] MCC_TEMP_MAX = 11'sh1FF;
  localparam logic signed [MCC_SUM_W-1:0] MCC_TEMP_MIN = -11'sh200;

  // ----------------------------------------------------------------
  // Temperature channels and single-channel selections
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MCC_TCH_REMOTE_ONE = 2'h0,
    MCC_TCH_LOCAL = 2'h1,
    MCC_TCH_REMOTE_TWO = 2'h2
  } mcc_temp_chan_type;

  typedef enum logic [2:0] {
    MCC_SEL_V2P5 = 3'h0,
    MCC_SEL_CORE = 3'h1,
    MCC_SEL_SUPPLY = 3'h2,
    MCC_SEL_V5 = 3'h3,
    MCC_SEL_V12 = 3'h4,
    MCC_SEL_REMOTE_ONE = 3'h5,
    MCC_SEL_LOCAL = 3'h6,
    MCC_SEL_REMOTE_TWO = 3'h7
  } mcc_single_channel_mode_sel_type;

endpackage

`default_nettype wire

//--- pkg/mcc_temp_if.sv
// Carrier between the register core and the offset adder.
`default_nettype none

interface mcc_temp_if;
  import mcc_pkg::*;

  logic signed [MCC_TEMP_W-1:0] raw;
  logic signed [7:0] offset;
  logic signed [MCC_TEMP_W-1:0] adjusted;

  modport core (output raw, output offset, input adjusted);
  modport adder (input raw, input offset, output adjusted);
endinterface

`default_nettype wire

//--- tb/mcc_regs_assertions.sv
// Concurrent checks on the monitor configuration register group ports.
`default_nettype none
module mcc_regs_assertions
  import mcc_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic CONFIG_LOCK,
  input wire logic [2:0] CHANNEL_SELECT,
  input wire logic EXT_START_ENABLE,
  input wire logic RAW_VALID,
  input wire logic [MCC_PWMS-1:0] PWM_POLARITY_FLIP,
  input wire logic ADJ_VALID,
  input wire logic PARITY_TREE_TEST_ON,
  input wire logic [MCC_FANS-1:0] TWO_WIRE_SENSE,
  input wire logic AVERAGING_DISABLE,
  input wire logic ATTENUATOR_BYPASS,
  input wire logic SINGLE_CHANNEL_MODE,
  input wire logic [2:0] SINGLE_CHANNEL_MODE_CHANNEL,
  input wire logic SINGLE_CHANNEL_MODE_START,
  input wire logic SHUTDOWN_SELECT,
  input wire logic [MCC_PWMS-1:0] PWM_OUT,
  input wire logic [8*MCC_PWMS-1:0] DUTY_READ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // Write data is kept one cycle so a consequent can compare against it.
  logic [7:0] wdat_q;
  logic wr_ok;
  logic [7:0] cfg2;
  assign wr_ok = REG_WR && !CONFIG_LOCK;
  assign cfg2 = {SHUTDOWN_SELECT, SINGLE_CHANNEL_MODE, ATTENUATOR_BYPASS,
                 AVERAGING_DISABLE, TWO_WIRE_SENSE};
  always_ff @(posedge CLK) begin
    wdat_q <= REG_WDATA;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_lock;
    REG_WR && CONFIG_LOCK |=> $stable(cfg2) && $stable(PARITY_TREE_TEST_ON);
  endproperty
  property p_xen;
    wr_ok && REG_ADDR == MCC_OFS_PARITY_TEST |=> PARITY_TREE_TEST_ON == wdat_q[0];
  endproperty
  property p_cfg2;
    wr_ok && REG_ADDR == MCC_OFS_MEAS_CONFIG_TWO |=> cfg2 == wdat_q;
  endproperty
  property p_rsv;
    REG_RD && REG_ADDR == MCC_OFS_PARITY_TEST |=> REG_RDATA[7:1] == 7'h00;
  endproperty
  property p_adj;
    RAW_VALID |=> ADJ_VALID;
  endproperty
  property p_sel;
    SINGLE_CHANNEL_MODE |=> SINGLE_CHANNEL_MODE_CHANNEL == $past(CHANNEL_SELECT);
  endproperty
  property p_start;
    SINGLE_CHANNEL_MODE_START |-> $past(SINGLE_CHANNEL_MODE) && $past(EXT_START_ENABLE)
      ##1 !SINGLE_CHANNEL_MODE_START;
  endproperty
  property p_pwm;
    SHUTDOWN_SELECT |=> PWM_OUT == $past(PWM_POLARITY_FLIP);
  endproperty
  property p_duty;
    SHUTDOWN_SELECT |=> DUTY_READ == '0;
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked write changed a field");
  a_xen: assert property (p_xen)
    else $error("test mode bit wrong");
  a_cfg2: assert property (p_cfg2)
    else $error("config outputs wrong");
  a_rsv: assert property (p_rsv)
    else $error("reserved bits not zero");
  a_adj: assert property (p_adj)
    else $error("adjusted result missing");
  a_sel: assert property (p_sel)
    else $error("channel not followed");
  a_start: assert property (p_start)
    else $error("bad start pulse");
  a_pwm: assert property (p_pwm)
    else $error("pwm not at fan-off");
  a_duty: assert property (p_duty)
    else $error("duty not zero");
  c_shutdown_select: cover property (SHUTDOWN_SELECT ##1 !SHUTDOWN_SELECT);
  c_start: cover property (SINGLE_CHANNEL_MODE_START);
  c_adj: cover property (ADJ_VALID);
endmodule

bind mcc_regs mcc_regs_assertions u_chk (.CLK(CLK), .RESET(RESET),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CONFIG_LOCK(CONFIG_LOCK),
  .CHANNEL_SELECT(CHANNEL_SELECT), .EXT_START_ENABLE(EXT_START_ENABLE),
  .RAW_VALID(RAW_VALID), .PWM_POLARITY_FLIP(PWM_POLARITY_FLIP),
  .ADJ_VALID(ADJ_VALID), .PARITY_TREE_TEST_ON(PARITY_TREE_TEST_ON),
  .TWO_WIRE_SENSE(TWO_WIRE_SENSE), .AVERAGING_DISABLE(AVERAGING_DISABLE),
  .ATTENUATOR_BYPASS(ATTENUATOR_BYPASS),
  .SINGLE_CHANNEL_MODE(SINGLE_CHANNEL_MODE), .SINGLE_CHANNEL_MODE_CHANNEL(SINGLE_CHANNEL_MODE_CHANNEL),
  .SINGLE_CHANNEL_MODE_START(SINGLE_CHANNEL_MODE_START), .SHUTDOWN_SELECT(SHUTDOWN_SELECT),
  .PWM_OUT(PWM_OUT), .DUTY_READ(DUTY_READ));
`default_nettype wire

//--- tb/mcc_regs_tb.sv
// Self-checking bench for the monitor configuration register group.
`default_nettype none
module mcc_regs_tb
  import mcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, wr, rd, lock, ext_en, pin, raw_v, adj_v, parity_tree_test_on, averaging_disable, attenuator_bypass;
  logic single, start, shutdown_select;
  logic [7:0] addr, wdata, rdata;
  logic [2:0] chsel, single_channel_mode_ch, pwm_in, flip, pwm_out;
  logic signed [MCC_TEMP_W-1:0] raw_t, adj_t;
  logic [1:0] raw_c, adj_c;
  logic [3:0] two_w;
  logic [23:0] duty_in, duty_rd;
  int n_fail, num_checks, cyc, pulses;
  mcc_regs uut (.CLK(clk), .RESET(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .CONFIG_LOCK(lock),
    .CHANNEL_SELECT(chsel), .EXT_START_ENABLE(ext_en), .FAN1_SENSE_PIN(pin),
    .RAW_TEMP(raw_t), .RAW_CHAN(raw_c), .RAW_VALID(raw_v), .PWM_IN(pwm_in),
    .PWM_POLARITY_FLIP(flip), .DUTY_IN(duty_in), .ADJ_TEMP(adj_t),
    .ADJ_CHAN(adj_c), .ADJ_VALID(adj_v), .PARITY_TREE_TEST_ON(parity_tree_test_on),
    .TWO_WIRE_SENSE(two_w), .AVERAGING_DISABLE(averaging_disable),
    .ATTENUATOR_BYPASS(attenuator_bypass), .SINGLE_CHANNEL_MODE(single),
    .SINGLE_CHANNEL_MODE_CHANNEL(single_channel_mode_ch), .SINGLE_CHANNEL_MODE_START(start), .SHUTDOWN_SELECT(shutdown_select),
    .PWM_OUT(pwm_out), .DUTY_READ(duty_rd));
  // ----------------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------------
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, e);
  endtask
  task automatic temp(input logic [1:0] c, input logic signed [9:0] r, e);
    @(posedge clk);
    raw_v <= 1'b1;
    raw_c <= c;
    raw_t <= r;
    @(posedge clk);
    raw_v <= 1'b0;
    #1 check(adj_v, 1'b1);
    check(adj_t, e);
    check(adj_c, c);
  endtask
  // The pin is held six cycles high then eight low, well over the sync depth.
  task automatic ext(input logic en, input int n);
    @(posedge clk);
    ext_en <= en;
    pulses = 0;
    for (int i = 0; i < 14; i++) begin
      @(posedge clk);
      pin <= (i < 6);
      #1 if (start === 1'b1) pulses++;
    end
    check(24'(pulses), 24'(n));
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    {rst, wr, rd, lock, ext_en, pin, raw_v} = 7'h40;
    {addr, wdata, chsel, raw_t, raw_c} = '0;
    pwm_in = 3'h5;
    flip = 3'h3;
    duty_in = 24'hA5C33C;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1 check({parity_tree_test_on, shutdown_select, single, attenuator_bypass, averaging_disable, two_w, single_channel_mode_ch}, '0);
    for (int a = 'h6F; a <= 'h73; a++) rd_reg(8'(a), 8'h00);
    rd_reg(8'h74, 8'h00);
    wr_reg(MCC_OFS_PARITY_TEST, 8'hFF);
    rd_reg(MCC_OFS_PARITY_TEST, 8'h01);
    check(parity_tree_test_on, 1'b1);
    wr_reg(MCC_OFS_PARITY_TEST, 8'h00);
    rd_reg(MCC_OFS_PARITY_TEST, 8'h00);
    check(parity_tree_test_on, 1'b0);
    for (int i = 0; i < 8; i++) begin
      wr_reg(MCC_OFS_MEAS_CONFIG_TWO, 8'(1 << i));
      rd_reg(MCC_OFS_MEAS_CONFIG_TWO, 8'(1 << i));
      check({shutdown_select, single, attenuator_bypass, averaging_disable, two_w}, 24'(1 << i));
    end
    wr_reg(MCC_OFS_MEAS_CONFIG_TWO, 8'h00);
    wr_reg(MCC_OFS_REMOTE_ONE_OFFSET, 8'h10);
    wr_reg(MCC_OFS_LOCAL_OFFSET, 8'hF0);
    wr_reg(MCC_OFS_REMOTE_TWO_OFFSET, 8'h80);
    rd_reg(MCC_OFS_LOCAL_OFFSET, 8'hF0);
    temp(2'h0, 10'sd500, 10'sd511);
    temp(2'h0, -10'sd20, -10'sd4);
    temp(2'h1, -10'sd500, -10'sd512);
    temp(2'h1, 10'sd40, 10'sd24);
    temp(2'h2, 10'sd100, -10'sd28);
    temp(2'h3, 10'sd7, 10'sd7);
    check(pwm_out, pwm_in);
    check(duty_rd, duty_in);
    wr_reg(MCC_OFS_MEAS_CONFIG_TWO, 8'h40);
    chsel <= 3'h5;
    repeat (2) @(posedge clk);
    #1 check(single_channel_mode_ch, 3'h5);
    ext(1'b1, 1);
    ext(1'b0, 0);
    wr_reg(MCC_OFS_MEAS_CONFIG_TWO, 8'h00);
    ext(1'b1, 0);
    wr_reg(MCC_OFS_MEAS_CONFIG_TWO, 8'h80);
    repeat (2) @(posedge clk);
    #1 check(pwm_out, flip);
    check(duty_rd, 24'h000000);
    @(posedge clk);
    lock <= 1'b1;
    wr_reg(MCC_OFS_MEAS_CONFIG_TWO, 8'h00);
    wr_reg(MCC_OFS_REMOTE_ONE_OFFSET, 8'h55);
    wr_reg(MCC_OFS_PARITY_TEST, 8'h01);
    rd_reg(MCC_OFS_MEAS_CONFIG_TWO, 8'h80);
    rd_reg(MCC_OFS_REMOTE_ONE_OFFSET, 8'h10);
    rd_reg(MCC_OFS_PARITY_TEST, 8'h00);
    check(shutdown_select, 1'b1);
    @(posedge clk);
    lock <= 1'b0;
    wr_reg(MCC_OFS_MEAS_CONFIG_TWO, 8'h00);
    repeat (2) @(posedge clk);
    #1 check(pwm_out, pwm_in);
    check(duty_rd, duty_in);
    conclude();
  end
endmodule
`default_nettype wire

//--- verilog/mcc_offset_adder.sv
// Signed offset adder with saturation for one temperature result.
`default_nettype none

module mcc_offset_adder
  import mcc_pkg::*;
(
  mcc_temp_if.adder port
);

  logic signed [MCC_SUM_W-1:0] sum;

  // ----------------------------------------------------------------
  // Add and clamp
  // ----------------------------------------------------------------
  // Clamping instead of wrapping keeps a hot reading from turning cold.
  always_comb begin
    sum = MCC_SUM_W'(port.raw) + MCC_SUM_W'(port.offset);
    if (sum > MCC_TEMP_MAX) begin
      port.adjusted = MCC_TEMP_MAX[MCC_TEMP_W-1:0];
    end else if (sum < MCC_TEMP_MIN) begin
      port.adjusted = MCC_TEMP_MIN[MCC_TEMP_W-1:0];
    end else begin
      port.adjusted = sum[MCC_TEMP_W-1:0];
    end
  end

endmodule

`default_nettype wire

//--- verilog/mcc_regs.sv
// Configuration and calibration register group of the hardware monitor.
//
// Decided for this implementation: strobed register access.
`default_nettype none

// What this block does
// - Bit 0 of the test enable register puts the device in parity tree test mode while set.
// - While the lock input is high every register here ignores writes.
// - The remote one offset, a signed quarter-degree count, is added to each remote one result.
// - The local offset, a signed quarter-degree count, is added to each local result.
// - The remote two offset, a signed quarter-degree count, is added to each remote two result.
// - Bits 0 to 3 pick two-wire sensing per fan input when one, three-wire pulses when zero.
// - Bit 4 turns averaging of temperature and voltage measurements off.
// - Bit 5 takes the input attenuators out of the four voltage inputs.
// - Bit 6 puts the converter in single-channel mode on one input only.
// - In single-channel mode the three-bit select from the fan one minimum register picks the channel.
// - In single-channel mode with the external start enable set, rising edges on the first fan sense pin start single conversions.
// - Bit 7 forces shutdown and drives each PWM output to its fan-off level, high when inverted.
// - In shutdown every current duty cycle reads back as zero.
// - The second configuration register resets to all zeros.
module mcc_regs
  import mcc_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic CONFIG_LOCK,
  input wire logic [2:0] CHANNEL_SELECT,
  input wire logic EXT_START_ENABLE,
  input wire logic FAN1_SENSE_PIN,
  input wire logic signed [MCC_TEMP_W-1:0] RAW_TEMP,
  input wire logic [1:0] RAW_CHAN,
  input wire logic RAW_VALID,
  input wire logic [MCC_PWMS-1:0] PWM_IN,
  input wire logic [MCC_PWMS-1:0] PWM_POLARITY_FLIP,
  input wire logic [8*MCC_PWMS-1:0] DUTY_IN,
  output logic signed [MCC_TEMP_W-1:0] ADJ_TEMP,
  output logic [1:0] ADJ_CHAN,
  output logic ADJ_VALID,
  output logic PARITY_TREE_TEST_ON,
  output logic [MCC_FANS-1:0] TWO_WIRE_SENSE,
  output logic AVERAGING_DISABLE,
  output logic ATTENUATOR_BYPASS,
  output logic SINGLE_CHANNEL_MODE,
  output logic [2:0] SINGLE_CHANNEL_MODE_CHANNEL,
  output logic SINGLE_CHANNEL_MODE_START,
  output logic SHUTDOWN_SELECT,
  output logic [MCC_PWMS-1:0] PWM_OUT,
  output logic [8*MCC_PWMS-1:0] DUTY_READ
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic parity_q, parity_d;
  logic [7:0] ofs_r1_q, ofs_r1_d;
  logic [7:0] ofs_loc_q, ofs_loc_d;
  logic [7:0] ofs_r2_q, ofs_r2_d;
  logic [7:0] cfg2_q, cfg2_d;
  logic [7:0] rdata_q, rdata_d;
  logic write_ok;

  logic [2:0] pin_sync_q, pin_sync_d;
  logic pin_level_q, pin_level_d;
  logic start_q, start_d;
  logic [2:0] single_channel_mode_chan_q, single_channel_mode_chan_d;

  logic signed [MCC_TEMP_W-1:0] adj_q, adj_d;
  logic [1:0] adj_chan_q, adj_chan_d;
  logic adj_valid_q, adj_valid_d;

  logic [MCC_PWMS-1:0] pwm_q, pwm_d;
  logic [8*MCC_PWMS-1:0] duty_q, duty_d;

  mcc_temp_if temp_bus ();

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // The lock only blocks writes; reads keep working so software can
  // still inspect a frozen configuration.
  assign write_ok = REG_WR && !CONFIG_LOCK;

  always_comb begin
    parity_d = parity_q;
    ofs_r1_d = ofs_r1_q;
    ofs_loc_d = ofs_loc_q;
    ofs_r2_d = ofs_r2_q;
    cfg2_d = cfg2_q;
    if (write_ok) begin
      case (REG_ADDR)
        MCC_OFS_PARITY_TEST: begin
          // Only the enable bit is kept; the upper bits are not stored.
          parity_d = REG_WDATA[MCC_BIT_PARITY_TEST_ON];
        end
        MCC_OFS_REMOTE_ONE_OFFSET: begin
          ofs_r1_d = REG_WDATA;
        end
        MCC_OFS_LOCAL_OFFSET: begin
          ofs_loc_d = REG_WDATA;
        end
        MCC_OFS_REMOTE_TWO_OFFSET: begin
          ofs_r2_d = REG_WDATA;
        end
        MCC_OFS_MEAS_CONFIG_TWO: begin
          cfg2_d = REG_WDATA;
        end
        default: begin
          parity_d = parity_q;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      parity_q <= MCC_RST_PARITY_TEST[MCC_BIT_PARITY_TEST_ON];
      ofs_r1_q <= MCC_RST_OFFSET;
      ofs_loc_q <= MCC_RST_OFFSET;
      ofs_r2_q <= MCC_RST_OFFSET;
      cfg2_q <= MCC_RST_MEAS_CONFIG_TWO;
    end else begin
      parity_q <= parity_d;
      ofs_r1_q <= ofs_r1_d;
      ofs_loc_q <= ofs_loc_d;
      ofs_r2_q <= ofs_r2_d;
      cfg2_q <= cfg2_d;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Read data stand for exactly one cycle; otherwise the bus reads zero,
  // and so does any address outside this group.
  always_comb begin
    rdata_d = MCC_READ_IDLE;
    if (REG_RD) begin
      case (REG_ADDR)
        MCC_OFS_PARITY_TEST: begin
          rdata_d = {7'h00, parity_q};
        end
        MCC_OFS_REMOTE_ONE_OFFSET: begin
          rdata_d = ofs_r1_q;
        end
        MCC_OFS_LOCAL_OFFSET: begin
          rdata_d = ofs_loc_q;
        end
        MCC_OFS_REMOTE_TWO_OFFSET: begin
          rdata_d = ofs_r2_q;
        end
        MCC_OFS_MEAS_CONFIG_TWO: begin
          rdata_d = cfg2_q;
        end
        default: begin
          rdata_d = MCC_READ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rdata_q <= MCC_READ_IDLE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Temperature offset correction
  // ----------------------------------------------------------------
  mcc_offset_adder u_adder (
    .port(temp_bus.adder)
  );

  always_comb begin
    temp_bus.raw = RAW_TEMP;
    case (RAW_CHAN)
      MCC_TCH_REMOTE_ONE: begin
        temp_bus.offset = ofs_r1_q;
      end
      MCC_TCH_LOCAL: begin
        temp_bus.offset = ofs_loc_q;
      end
      MCC_TCH_REMOTE_TWO: begin
        temp_bus.offset = ofs_r2_q;
      end
      default: begin
        temp_bus.offset = MCC_RST_OFFSET;
      end
    endcase
  end

  // The corrected value is registered once; downstream limit logic only
  // ever sees the adjusted result.
  always_comb begin
    adj_d = adj_q;
    adj_chan_d = adj_chan_q;
    adj_valid_d = RAW_VALID;
    if (RAW_VALID) begin
      adj_d = temp_bus.adjusted;
      adj_chan_d = RAW_CHAN;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      adj_q <= '0;
      adj_chan_q <= 2'h0;
      adj_valid_q <= 1'b0;
    end else begin
      adj_q <= adj_d;
      adj_chan_q <= adj_chan_d;
      adj_valid_q <= adj_valid_d;
    end
  end

  // ----------------------------------------------------------------
  // Conversion control
  // ----------------------------------------------------------------
  // The fan sense pin is asynchronous: three stages, and a change is
  // taken only once the second and third stages agree.
  always_comb begin
    pin_sync_d = {pin_sync_q[1:0], FAN1_SENSE_PIN};
    pin_level_d = pin_level_q;
    if (pin_sync_q[1] == pin_sync_q[2]) begin
      pin_level_d = pin_sync_q[2];
    end
    start_d = 1'b0;
    if (cfg2_q[MCC_BIT_SINGLE_CHANNEL] && EXT_START_ENABLE &&
        pin_level_d && !pin_level_q) begin
      start_d = 1'b1;
    end
    single_channel_mode_chan_d = single_channel_mode_chan_q;
    if (cfg2_q[MCC_BIT_SINGLE_CHANNEL]) begin
      single_channel_mode_chan_d = CHANNEL_SELECT;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pin_sync_q <= 3'h0;
      pin_level_q <= 1'b0;
      start_q <= 1'b0;
      single_channel_mode_chan_q <= MCC_SEL_V2P5;
    end else begin
      pin_sync_q <= pin_sync_d;
      pin_level_q <= pin_level_d;
      start_q <= start_d;
      single_channel_mode_chan_q <= single_channel_mode_chan_d;
    end
  end

  // ----------------------------------------------------------------
  // Shutdown effects on fan drive
  // ----------------------------------------------------------------
  // A fan-off level depends on polarity, so inverted outputs sit high.
  always_comb begin
    if (cfg2_q[MCC_BIT_SHUTDOWN_SELECT]) begin
      pwm_d = PWM_POLARITY_FLIP;
      duty_d = {MCC_PWMS{MCC_DUTY_IDLE}};
    end else begin
      pwm_d = PWM_IN;
      duty_d = DUTY_IN;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pwm_q <= '0;
      duty_q <= '0;
    end else begin
      pwm_q <= pwm_d;
      duty_q <= duty_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign REG_RDATA = rdata_q;
  assign ADJ_TEMP = adj_q;
  assign ADJ_CHAN = adj_chan_q;
  assign ADJ_VALID = adj_valid_q;
  assign PARITY_TREE_TEST_ON = parity_q;
  assign TWO_WIRE_SENSE =
    cfg2_q[MCC_BIT_TWO_WIRE_HI:MCC_BIT_TWO_WIRE_LO];
  assign AVERAGING_DISABLE = cfg2_q[MCC_BIT_AVERAGING_DISABLE];
  assign ATTENUATOR_BYPASS = cfg2_q[MCC_BIT_ATTENUATOR_BYPASS];
  assign SINGLE_CHANNEL_MODE = cfg2_q[MCC_BIT_SINGLE_CHANNEL];
  assign SINGLE_CHANNEL_MODE_CHANNEL = single_channel_mode_chan_q;
  assign SINGLE_CHANNEL_MODE_START = start_q;
  assign SHUTDOWN_SELECT = cfg2_q[MCC_BIT_SHUTDOWN_SELECT];
  assign PWM_OUT = pwm_q;
  assign DUTY_READ = duty_q;

endmodule

`default_nettype wire
